// ### bench/mpsr_host.sv
// Host model shifting words into the serial port
`timescale 1ns/1ps
module mpsr_host (
    output logic ser_clk,
    output logic ser_data,
    output logic strobe
);
    initial
    begin
        ser_clk = 1'b1;
        ser_data = 1'b0;
        strobe = 1'b0;
    end
    // ==========================================================
    // One frame: 16 bits LSB first, then strobe with target bit
    task automatic send(input logic [15:0] w, input logic ext);
        integer i;
        for (i = 0; i < 16; i++)
        begin
            ser_data = w[i];
            #200 ser_clk = 1'b0;
            #200 ser_clk = 1'b1;
        end
        ser_data = ext;
        #200 strobe = 1'b1;
        #200 ser_data = ~ext;
        strobe = 1'b0;
        #200;
    endtask
endmodule // mpsr_host

// ### bench/mpsr_top_properties.sv
// Concurrent checks on the serial setup register block ports
`timescale 1ns/1ps
module mpsr_top_properties (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire RESET_IN_N,
    input wire SLEEP_N_PIN,
    input wire WAKE_N_PIN,
    input wire RESET_REQ,
    input wire [8:0] FAULT_IN,
    input wire RESET_OUT_N,
    input wire INTERNAL_SLEEP_N,
    input wire DEEP_SLEEP,
    input wire MONITOR_OUT,
    input wire [15:0] SETUP_BANK_ZERO,
    input wire [15:0] SETUP_BANK_ONE,
    input wire [15:0] EXTENDED_SETUP,
    input wire [3:0] SHUTDOWN_MASK,
    input wire [3:0] SELECTIVE_SHUTDOWN,
    input wire [1:0] THERMAL_RECOVERY,
    input wire MOTOR_RECOVERY,
    input wire THERMAL_WARNING_SELECT
);
    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!ARST_N);
    // ==========================================================
    // Sequences
    sequence s_delayed_req;
        $rose(RESET_REQ) && SETUP_BANK_ZERO[12] && RESET_OUT_N;
    endsequence
    sequence s_blocked;
        (INTERNAL_SLEEP_N && RESET_OUT_N && RESET_IN_N)[*6];
    endsequence
    // ==========================================================
    // Assertions
    a_sleep_held_high: assert property (
        !RESET_OUT_N && !$past(RESET_OUT_N) |-> INTERNAL_SLEEP_N)
        else $error("internal sleep low while reset output low");
    a_sleep_follows_pin: assert property (
        (RESET_OUT_N && $stable(SLEEP_N_PIN))[*5] |-> INTERNAL_SLEEP_N == SLEEP_N_PIN)
        else $error("internal sleep does not follow pin");
    a_strobe_blocked: assert property (s_blocked |-> $stable(SETUP_BANK_ZERO)
        && $stable(SETUP_BANK_ONE) && $stable(EXTENDED_SETUP))
        else $error("register latched while sleep high");
    a_bank_zero_sel: assert property (
        $changed(SETUP_BANK_ZERO) |-> !SETUP_BANK_ZERO[15])
        else $error("bank zero written with bank bit set");
    a_bank_one_sel: assert property (
        $changed(SETUP_BANK_ONE) && SETUP_BANK_ONE != 16'h0000 |-> SETUP_BANK_ONE[15])
        else $error("bank one written with bank bit clear");
    a_mask_copy: assert property ({SELECTIVE_SHUTDOWN, SHUTDOWN_MASK}
        == $past(EXTENDED_SETUP[11:4]))
        else $error("mask fields differ from extended setup");
    a_recovery_copy: assert property (
        {MOTOR_RECOVERY, THERMAL_RECOVERY, THERMAL_WARNING_SELECT}
        == $past(EXTENDED_SETUP[15:12]))
        else $error("recovery fields differ from extended setup");
    a_monitor_fixed: assert property (
        (EXTENDED_SETUP[3:0] == 4'hF)[*2] |-> MONITOR_OUT)
        else $error("monitor not high for fixed code");
    a_monitor_fault: assert property (
        (EXTENDED_SETUP[3:0] == 4'h0 && FAULT_IN[0])[*5] |-> !MONITOR_OUT)
        else $error("monitor not low on converter fault");
    a_monitor_ldo: assert property (
        (EXTENDED_SETUP[3:0] == 4'hE && FAULT_IN[8])[*5] |-> !MONITOR_OUT)
        else $error("monitor not low on linear regulator fault");
    a_deep_enter: assert property ((SETUP_BANK_ONE[11] && WAKE_N_PIN)[*5] |-> DEEP_SLEEP)
        else $error("deep sleep not entered");
    a_deep_cause: assert property (DEEP_SLEEP |-> $past(SETUP_BANK_ONE[11]))
        else $error("deep sleep without its bit");
    a_delay_holds: assert property (s_delayed_req |=> RESET_OUT_N[*8])
        else $error("reset output not delayed");
endmodule // mpsr_top_properties

// ### bench/mpsr_top_tb.sv
// Self-checking testbench of the serial setup register block
`timescale 1ns/1ps
module mpsr_top_tb;
    logic clk, arst_n, rst_in_n, reg_up, sleep_n, wake_n, rst_req;
    logic [8:0] fault;
    wire ser_clk, ser_data, strobe, rst_out_n, int_sleep_n, deep, mon;
    wire [15:0] b0, b1, bx;
    logic [15:0] exp0, exp1, expx, w;
    integer failures, checks, i;
    mpsr_host u_host (.ser_clk(ser_clk), .ser_data(ser_data), .strobe(strobe));
    mpsr_top #(.ORT_CYCLES(50)) uut (.SYS_CLK(clk), .ARST_N(arst_n), .UV_N(1'b1),
        .RESET_IN_N(rst_in_n), .REG_UP(reg_up), .SLEEP_N_PIN(sleep_n), .STROBE_LINE(strobe),
        .SER_CLK(ser_clk), .SER_DATA(ser_data), .CHANNEL_CONFIG_PIN(1'b1), .WAKE_N_PIN(wake_n),
        .RESET_REQ(rst_req), .FAULT_IN(fault), .RESET_OUT_N(rst_out_n),
        .INTERNAL_SLEEP_N(int_sleep_n), .DEEP_SLEEP(deep), .MONITOR_OUT(mon),
        .SETUP_BANK_ZERO(b0), .SETUP_BANK_ONE(b1), .EXTENDED_SETUP(bx), .SHUTDOWN_MASK(),
        .SELECTIVE_SHUTDOWN(), .THERMAL_RECOVERY(), .MOTOR_RECOVERY(),
        .THERMAL_WARNING_SELECT());
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ==========================================================
    // Checking helpers
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    function automatic void apply(input logic [15:0] v, input logic x);
        if (x) expx = v;
        else if (v[15]) exp1 = v;
        else exp0 = v;
    endfunction
    task chk_regs;
        check(b0, exp0);
        check(b1, exp1);
        check(bx, expx);
    endtask
    task wr(input logic [15:0] v, input logic x, input logic take);
        u_host.send(v, x);
        if (take) apply(v, x);
        repeat (8) @(negedge clk);
        chk_regs;
    endtask
    task give_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        failures = 0;
        checks = 0;
        arst_n = 1'b0;
        rst_in_n = 1'b1;
        reg_up = 1'b0;
        sleep_n = 1'b0;
        wake_n = 1'b1;
        rst_req = 1'b0;
        fault = 9'h000;
        exp0 = 16'h2380;
        exp1 = 16'h0000;
        expx = 16'h0000;
        i = $urandom(32'hB492A0B4);
        repeat (10) @(negedge clk);
        arst_n = 1'b1;
        repeat (5) @(negedge clk);
        chk_regs;
        wr(16'h1234, 1'b0, 1'b0);
        check(int_sleep_n, 1'b1);
        reg_up = 1'b1;
        repeat (40) @(negedge clk);
        check(rst_out_n, 1'b0);
        repeat (30) @(negedge clk);
        check(rst_out_n, 1'b1);
        check(int_sleep_n, 1'b0);
        wr(16'h0000, 1'b0, 1'b1);
        wr(16'hFFFF, 1'b1, 1'b1);
        wr(16'h7FFF, 1'b0, 1'b1);
        for (i = 0; i < 12; i++)
        begin
            w = $urandom;
            wr(w, ($urandom % 3) == 0, 1'b1);
        end
        sleep_n = 1'b1;
        repeat (10) @(negedge clk);
        check(int_sleep_n, 1'b1);
        wr(16'h5555, 1'b0, 1'b0);
        sleep_n = 1'b0;
        repeat (10) @(negedge clk);
        wr(16'h000F, 1'b1, 1'b1);
        check(mon, 1'b1);
        wr(16'h000D, 1'b1, 1'b1);
        check(mon, 1'b1);
        fault = 9'h100;
        wr(16'h000E, 1'b1, 1'b1);
        check(mon, 1'b0);
        fault = 9'h001;
        wr(16'h0000, 1'b1, 1'b1);
        check(mon, 1'b0);
        fault = 9'h000;
        wr(16'h8800, 1'b0, 1'b1);
        check(deep, 1'b1);
        wake_n = 1'b0;
        repeat (6) @(negedge clk);
        check(deep, 1'b0);
        wake_n = 1'b1;
        wr(16'h1000, 1'b0, 1'b1);
        rst_req = 1'b1;
        repeat (1690) @(negedge clk);
        check(rst_out_n, 1'b1);
        repeat (335) @(negedge clk);
        check(rst_out_n, 1'b0);
        check(int_sleep_n, 1'b1);
        rst_req = 1'b0;
        repeat (40) @(negedge clk);
        check(rst_out_n, 1'b1);
        wr(16'hABCD, 1'b1, 1'b1);
        rst_in_n = 1'b0;
        repeat (6) @(negedge clk);
        exp0 = 16'h2380;
        exp1 = 16'h0000;
        expx = 16'h0000;
        chk_regs;
        check(int_sleep_n, 1'b1);
        wr(16'h2222, 1'b1, 1'b0);
        give_verdict;
    end
    initial
    begin
        #1000000;
        failures = failures + 1;
        give_verdict;
    end
endmodule // mpsr_top_tb
bind mpsr_top mpsr_top_properties u_props (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
    .RESET_IN_N(RESET_IN_N), .SLEEP_N_PIN(SLEEP_N_PIN), .WAKE_N_PIN(WAKE_N_PIN),
    .RESET_REQ(RESET_REQ), .FAULT_IN(FAULT_IN), .RESET_OUT_N(RESET_OUT_N),
    .INTERNAL_SLEEP_N(INTERNAL_SLEEP_N), .DEEP_SLEEP(DEEP_SLEEP), .MONITOR_OUT(MONITOR_OUT),
    .SETUP_BANK_ZERO(SETUP_BANK_ZERO), .SETUP_BANK_ONE(SETUP_BANK_ONE),
    .EXTENDED_SETUP(EXTENDED_SETUP), .SHUTDOWN_MASK(SHUTDOWN_MASK),
    .SELECTIVE_SHUTDOWN(SELECTIVE_SHUTDOWN), .THERMAL_RECOVERY(THERMAL_RECOVERY),
    .MOTOR_RECOVERY(MOTOR_RECOVERY), .THERMAL_WARNING_SELECT(THERMAL_WARNING_SELECT));

// ### core/mpsr_defines.vh
// Constants for the motor and regulator serial setup register block
`ifndef MPSR_DEFINES_VH
`define MPSR_DEFINES_VH

// ==========================================================
// Word layout
`define MPSR_WORD_W 16
`define MPSR_CNT_W 5
`define MPSR_BANK_BIT 15

// ==========================================================
// Bank 0 fields
`define MPSR_B0_BLANK_A_LSB 0
`define MPSR_B0_BLANK_B_LSB 2
`define MPSR_B0_BLANK_C_LSB 4
`define MPSR_B0_OFFT_A_BIT 6
`define MPSR_B0_SW_A_BIT 7
`define MPSR_B0_SW_B_BIT 8
`define MPSR_B0_SW_C_BIT 9
`define MPSR_B0_CHOP_LSB 10
`define MPSR_B0_RDLY_BIT 12
`define MPSR_B0_LIN_BIT 13
`define MPSR_B0_OFFT_B_BIT 14

// ==========================================================
// Bank 1 fields
`define MPSR_B1_SBLANK_AB_LSB 0
`define MPSR_B1_SBLANK_C_LSB 2
`define MPSR_B1_EXT_A_BIT 4
`define MPSR_B1_LVL_A_LSB 5
`define MPSR_B1_OFFT_C_BIT 7
`define MPSR_B1_EXT_B_BIT 8
`define MPSR_B1_LVL_B_LSB 9
`define MPSR_B1_DEEP_BIT 11
`define MPSR_B1_EXT_C_BIT 12
`define MPSR_B1_LVL_C_LSB 13

// ==========================================================
// Extended setup fields
`define MPSR_EX_SEL_LSB 0
`define MPSR_EX_MASK_LSB 4
`define MPSR_EX_SELSD_LSB 8
`define MPSR_EX_TWARN_BIT 12
`define MPSR_EX_TCTL_LSB 13
`define MPSR_EX_MCTL_BIT 15

// ==========================================================
// Reset values
`define MPSR_B0_RESET 16'h0080
`define MPSR_B1_RESET 16'h0000
`define MPSR_EX_RESET 16'h0000

// ==========================================================
// Timing
`define MPSR_CLK_NS 50
`define MPSR_ORT_MS 120
`define MPSR_RDLY_US 100
`define MPSR_ORT_CYC (`MPSR_ORT_MS * 1000000 / `MPSR_CLK_NS)
`define MPSR_RDLY_CYC (`MPSR_RDLY_US * 1000 / `MPSR_CLK_NS)
`define MPSR_TMR_W 22

`endif

// ### core/mpsr_shift.v
// Sixteen-bit serial shift register, LSB first
`timescale 1ns/1ps
`include "mpsr_defines.vh"
module mpsr_shift (
    input wire clk,
    input wire arst_n,
    input wire shift_en,
    input wire data_bit,
    output reg [`MPSR_WORD_W-1:0] word
);
    // Not cleared by power-up or reset input; first bit enters at the top
    always @(posedge clk)
    begin
        if (shift_en)
            word <= {data_bit, word[`MPSR_WORD_W-1:1]};
    end
endmodule // mpsr_shift

// ### core/mpsr_sync.v
// Two-flop synchroniser for a vector of pins
`timescale 1ns/1ps
module mpsr_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire arst_n,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end
        else
        begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule // mpsr_sync

// ### core/mpsr_top.v
// Serial setup register block of a motor and regulator combo device
// Overview of operation
// - Internal sleep held high until reset output rises, then follows sleep pin.
// - Strobe rise with internal sleep low copies shift word into chosen register.
// - Strobes blocked at power-up until reset output releases after 120 ms.
// - Shift register not initialised; host sends one command before latching.
// - Bank 0 bit pairs set bridge blanking times.
// - Off-time bits: bank 0 bits 6 and 14, bank 1 bit 7.
// - Bank 0 switches converters and linear regulator; converter B, C and regulator defaults from channel pin.
// - Bank 0 bits 11:10 set motor chopping frequency.
// - Bank 0 bit 12 delays reset output assertion by about 100 us.
// - Bank 1 bits 3:0 set short-detect blanking.
// - Bank 1 bits 4, 8, 12 select external sensing; level codes per bridge.
// - External sensing level codes select sense voltage trips.
// - All setup bits return to defaults on undervoltage or reset input low.
// - Extended bit 12 selects thermal warning or analog output.
// - Extended bits 14:13 set recovery after thermal shutdown.
// - Extended bit 15 sets recovery after motor overcurrent shutdown.
// - Bank 1 bit 11 enters deep sleep; wake pin low leaves it only while held low, as bit 11 stays set.
// - Extended bits 3:0 route a fault flag or identity bit to monitor pin.
// - Extended bits 11:8 make regulator faults shut down only that regulator.
`timescale 1ns/1ps
`include "mpsr_defines.vh"
module mpsr_top #(
    parameter ORT_CYCLES = `MPSR_ORT_CYC,
    // Arbitrary identity values
    parameter REV_CODE = 3'h5,
    parameter DEV_CODE = 2'h2
) (
    input wire SYS_CLK,
    input wire ARST_N,
    input wire UV_N,
    input wire RESET_IN_N,
    input wire REG_UP,
    input wire SLEEP_N_PIN,
    input wire STROBE_LINE,
    input wire SER_CLK,
    input wire SER_DATA,
    input wire CHANNEL_CONFIG_PIN,
    input wire WAKE_N_PIN,
    input wire RESET_REQ,
    input wire [8:0] FAULT_IN,
    output reg RESET_OUT_N,
    output reg INTERNAL_SLEEP_N,
    output reg DEEP_SLEEP,
    output reg MONITOR_OUT,
    output reg [15:0] SETUP_BANK_ZERO,
    output reg [15:0] SETUP_BANK_ONE,
    output reg [15:0] EXTENDED_SETUP,
    output reg [3:0] SHUTDOWN_MASK,
    output reg [3:0] SELECTIVE_SHUTDOWN,
    output reg [1:0] THERMAL_RECOVERY,
    output reg MOTOR_RECOVERY,
    output reg THERMAL_WARNING_SELECT
);
    // ==========================================================
    // Pin synchronisers
    wire [8:0] pin_sync;
    wire s_uv_n;
    wire s_rst_n;
    wire s_reg_up;
    wire external_sleep_n;
    wire s_strobe;
    wire s_sclk;
    wire s_data;
    wire s_csel;
    wire s_wake_n;

    mpsr_sync #(
        .W(9)
    ) u_sync (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .din({UV_N, RESET_IN_N, REG_UP, SLEEP_N_PIN, STROBE_LINE, SER_CLK,
              SER_DATA, CHANNEL_CONFIG_PIN, WAKE_N_PIN}),
        .dout(pin_sync)
    );

    assign s_uv_n = pin_sync[8];
    assign s_rst_n = pin_sync[7];
    assign s_reg_up = pin_sync[6];
    assign external_sleep_n = pin_sync[5];
    assign s_strobe = pin_sync[4];
    assign s_sclk = pin_sync[3];
    assign s_data = pin_sync[2];
    assign s_csel = pin_sync[1];
    assign s_wake_n = pin_sync[0];

    // ==========================================================
    // Fault flag synchroniser
    wire [8:0] fault_sync;

    mpsr_sync #(
        .W(9)
    ) u_fault_sync (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .din(FAULT_IN),
        .dout(fault_sync)
    );

    // ==========================================================
    // Edge detection
    // Link edges found on the system clock
    reg prev_strobe;
    reg prev_sclk;
    reg prev_data;
    wire strobe_rise;
    wire sclk_fall;
    // Power-up clear: undervoltage or reset input
    wire power_up_clear_n;

    assign strobe_rise = s_strobe & ~prev_strobe;
    assign sclk_fall = prev_sclk & ~s_sclk;
    assign power_up_clear_n = s_uv_n & s_rst_n;

    always @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            prev_strobe <= 1'b0;
            prev_sclk <= 1'b0;
            prev_data <= 1'b0;
        end
        else
        begin
            prev_strobe <= s_strobe;
            prev_sclk <= s_sclk;
            prev_data <= s_data;
        end
    end

    // ==========================================================
    // Shift register
    wire [15:0] shift_word;

    mpsr_shift u_shift (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .shift_en(sclk_fall),
        .data_bit(prev_data),
        .word(shift_word)
    );

    // ==========================================================
    // Reset output sequencing
    localparam ST_CLEAR = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam ST_DELAY = 2'h3;
    localparam integer ORT_INT = ORT_CYCLES;
    localparam integer RDLY_INT = `MPSR_RDLY_CYC;
    localparam [21:0] ORT_CNT = ORT_INT[21:0];
    localparam [21:0] RDLY_CNT = RDLY_INT[21:0];

    reg [1:0] state;
    reg [1:0] next_state;
    // Timer counts both the release and the assertion delay
    reg [21:0] timer;
    reg [21:0] next_timer;
    reg next_reset_out_n;
    reg csel_cap;

    always @*
    begin
        next_state = state;
        next_timer = timer;
        next_reset_out_n = RESET_OUT_N;
        case (state)
            ST_CLEAR:
            begin
                next_reset_out_n = 1'b0;
                next_timer = 22'h000000;
                if (s_reg_up)
                    next_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (timer >= ORT_CNT - 22'h000001)
                begin
                    next_reset_out_n = 1'b1;
                    next_state = ST_RUN;
                end
                else
                    next_timer = timer + 22'h000001;
            end
            ST_RUN:
            begin
                next_timer = 22'h000000;
                if (RESET_REQ)
                begin
                    if (SETUP_BANK_ZERO[`MPSR_B0_RDLY_BIT])
                        next_state = ST_DELAY;
                    else
                    begin
                        next_reset_out_n = 1'b0;
                        next_state = ST_CLEAR;
                    end
                end
            end
            ST_DELAY:
            begin
                if (timer >= RDLY_CNT - 22'h000001)
                begin
                    next_reset_out_n = 1'b0;
                    next_state = ST_CLEAR;
                end
                else
                    next_timer = timer + 22'h000001;
            end
            default:
            begin
                next_state = ST_CLEAR;
            end
        endcase
        if (!power_up_clear_n)
        begin
            next_state = ST_CLEAR;
            next_reset_out_n = 1'b0;
            next_timer = 22'h000000;
        end
    end

    always @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state <= ST_CLEAR;
            timer <= 22'h000000;
            RESET_OUT_N <= 1'b0;
        end
        else
        begin
            state <= next_state;
            timer <= next_timer;
            RESET_OUT_N <= next_reset_out_n;
        end
    end

    // ==========================================================
    // Internal sleep
    // Held high until the reset output releases
    always @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
            INTERNAL_SLEEP_N <= 1'b1;
        else if (!RESET_OUT_N || !power_up_clear_n)
            INTERNAL_SLEEP_N <= 1'b1;
        else
            INTERNAL_SLEEP_N <= external_sleep_n;
    end

    // ==========================================================
    // Setup registers
    wire latch_en;
    wire [15:0] b0_default;

    // Strobe refused while internal sleep is high
    assign latch_en = strobe_rise & ~INTERNAL_SLEEP_N;
    // Converter B and C and linear regulator default from channel pin
    assign b0_default = `MPSR_B0_RESET | {2'h0, csel_cap, 3'h0, csel_cap, csel_cap, 8'h00};

    always @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            csel_cap <= 1'b0;
            SETUP_BANK_ZERO <= `MPSR_B0_RESET;
            SETUP_BANK_ONE <= `MPSR_B1_RESET;
            EXTENDED_SETUP <= `MPSR_EX_RESET;
        end
        else if (!power_up_clear_n)
        begin
            csel_cap <= s_csel;
            SETUP_BANK_ZERO <= b0_default;
            SETUP_BANK_ONE <= `MPSR_B1_RESET;
            EXTENDED_SETUP <= `MPSR_EX_RESET;
        end
        else if (state == ST_CLEAR && !s_reg_up)
        begin
            csel_cap <= s_csel;
            SETUP_BANK_ZERO <= b0_default;
        end
        else if (latch_en)
        begin
            // Data high at the strobe edge picks extended setup
            if (s_data)
                EXTENDED_SETUP <= shift_word;
            else if (shift_word[`MPSR_BANK_BIT])
                SETUP_BANK_ONE <= shift_word;
            else
                SETUP_BANK_ZERO <= shift_word;
        end
    end

    // ==========================================================
    // Decoded controls
    reg [15:0] monitor_src;

    always @*
    begin
        // Fault codes read low while the fault stands
        monitor_src[7:0] = ~fault_sync[7:0];
        // Identity codes pass their bit
        monitor_src[10:8] = REV_CODE;
        monitor_src[12:11] = DEV_CODE;
        // Spare code and fixed code read high
        monitor_src[13] = 1'b1;
        monitor_src[15] = 1'b1;
        // Regulator fault code reads low on fault
        monitor_src[14] = ~fault_sync[8];
    end

    always @(posedge SYS_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            SHUTDOWN_MASK <= 4'h0;
            SELECTIVE_SHUTDOWN <= 4'h0;
            THERMAL_RECOVERY <= 2'h0;
            MOTOR_RECOVERY <= 1'b0;
            THERMAL_WARNING_SELECT <= 1'b0;
            MONITOR_OUT <= 1'b1;
            DEEP_SLEEP <= 1'b0;
        end
        else
        begin
            SHUTDOWN_MASK <= EXTENDED_SETUP[`MPSR_EX_MASK_LSB+3:`MPSR_EX_MASK_LSB];
            SELECTIVE_SHUTDOWN <= EXTENDED_SETUP[`MPSR_EX_SELSD_LSB+3:`MPSR_EX_SELSD_LSB];
            THERMAL_RECOVERY <= EXTENDED_SETUP[`MPSR_EX_TCTL_LSB+1:`MPSR_EX_TCTL_LSB];
            MOTOR_RECOVERY <= EXTENDED_SETUP[`MPSR_EX_MCTL_BIT];
            THERMAL_WARNING_SELECT <= EXTENDED_SETUP[`MPSR_EX_TWARN_BIT];
            MONITOR_OUT <= monitor_src[EXTENDED_SETUP[3:0]];
            // Deep sleep while the bit is set and wake is high
            if (SETUP_BANK_ONE[`MPSR_B1_DEEP_BIT] && s_wake_n)
                DEEP_SLEEP <= 1'b1;
            else
                DEEP_SLEEP <= 1'b0;
        end
    end
endmodule // mpsr_top
